// [core/rsf_exec.sv]
// rsf_exec: decode and execute of rotate-right-no-carry and set-all-ones
// file-register instructions, one instruction per four-phase cycle.
// assumes the instruction word is held stable by fetch logic on the same
// clock and sampled at the first phase; read data is valid while the read
// strobe is high and is latched at the end of that phase.
//
// Function
// - rotate moves bit n to n-1 and bit 0 to bit 7, updating only negative and zero flags.
// - rotate destination bit 0 writes working_reg, 1 writes back to the file register.
// - access bit 0 uses the access bank ignoring bank_select_reg; 1 uses bank_select_reg.
// - access bit 0 with extended set enabled and address at most 5Fh uses indexed literal offset.
// - set writes FFh into the addressed file register and leaves all flags unchanged.
// - set uses the access bank when access bit is clear, bank_select_reg when set.
// - opcodes are 0100 00da and 0110 100a each followed by an 8-bit address, one word each.
`timescale 1ns/1ps
`default_nettype none
module rsf_exec #(
   parameter int BANK_W = 4
) (
   input wire logic i_clk_sys,                    // 250 MHz core clock
   input wire logic i_rst_b,                      // async reset, active low
   input wire logic [15:0] i_instr,               // instruction word
   input wire logic i_instr_vld,                  // word present at phase 1
   input wire logic i_ext_set_en,                 // extended set enabled
   input wire logic [BANK_W-1:0] i_bank_sel,      // bank_select_reg value
   input wire logic [BANK_W+7:0] i_idx_base,      // indexed offset base
   input wire logic [7:0] i_mem_rdata,            // data memory read data
   output logic o_cyc_start,                      // phase 1 marker
   output logic [BANK_W+7:0] o_mem_addr,          // data memory address
   output logic o_mem_rd,                         // read strobe, phase 2
   output logic o_mem_wr,                         // write strobe, phase 4
   output logic [7:0] o_mem_wdata,                // write data
   output logic o_wreg_we,                        // working_reg write
   output logic [7:0] o_wreg_data,                // working_reg data
   output logic o_flag_we,                        // negative/zero update
   output logic o_neg_flag,                       // negative flag value
   output logic o_zero_flag,                      // zero flag value
   output logic o_op_hit                          // recognised op in flight
);
   import rsf_pkg::*;

   logic rst_s1_q;
   logic rst_s2_q;
   wire rst_n = rst_s2_q;

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   rsf_phase_t phase_q;
   rsf_phase_t phase_d;
   rsf_op_t op_q;
   rsf_op_t op_d;
   logic [15:0] instr_q;
   logic [BANK_W+7:0] addr_q;
   logic [7:0] res_q;
   logic [7:0] res_d;
   logic zero_q;
   logic [7:0] opnd_q;

   // decode works on the live word so the address is ready by phase 2
   wire is_rot =
      i_instr[RSF_ROT_OPC_MSB:RSF_ROT_OPC_LSB] == RSF_ROT_OPC;
   wire is_set =
      i_instr[RSF_ROT_OPC_MSB:RSF_SET_OPC_LSB] == RSF_SET_OPC;
   wire [7:0] f_addr = i_instr[7:0];
   wire acc_bit = i_instr[RSF_ACC_BIT];
   wire dest_f = instr_q[RSF_DEST_BIT];
   wire use_idx =
      !acc_bit && i_ext_set_en && (f_addr <= RSF_IDX_MAX);
   wire [BANK_W-1:0] acc_bank = (f_addr < RSF_ACC_SPLIT) ?
      {BANK_W{1'b0}} : {BANK_W{1'b1}};
   // banked: bank_select_reg only when the access bit is set
   wire [BANK_W-1:0] bank = acc_bit ? i_bank_sel : acc_bank;
   wire [BANK_W+7:0] idx_addr = i_idx_base + {{BANK_W{1'b0}}, f_addr};
   wire [BANK_W+7:0] eff_addr = use_idx ? idx_addr : {bank, f_addr};
   wire [7:0] rot_res = {opnd_q[0], opnd_q[7:1]};

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         RSF_Q1: phase_d = RSF_Q2;
         RSF_Q2: phase_d = RSF_Q3;
         RSF_Q3: phase_d = RSF_Q4;
         RSF_Q4: phase_d = RSF_Q1;
         default: phase_d = RSF_Q1;
      endcase
   end

   always_comb begin
      op_d = op_q;
      if (phase_q == RSF_Q1) begin
         if (!i_instr_vld) begin
            op_d = RSF_OP_NONE;
         end else if (is_rot) begin
            op_d = RSF_OP_ROT;
         end else if (is_set) begin
            op_d = RSF_OP_SET;
         end else begin
            op_d = RSF_OP_NONE;
         end
      end
   end

   // result formed in phase 3 from the operand read in phase 2
   always_comb begin
      res_d = res_q;
      if (phase_q == RSF_Q3) begin
         if (op_q == RSF_OP_ROT) begin
            res_d = rot_res;
         end else if (op_q == RSF_OP_SET) begin
            res_d = RSF_ALL_ONES;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= RSF_Q1;
         op_q <= RSF_OP_NONE;
      end else begin
         phase_q <= phase_d;
         op_q <= op_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         instr_q <= RSF_INSTR_RST;
         addr_q <= '0;
         res_q <= RSF_ZERO_BYTE;
         zero_q <= 1'b0;
         opnd_q <= RSF_ZERO_BYTE;
      end else begin
         if (phase_q == RSF_Q1) begin
            instr_q <= i_instr;
            addr_q <= eff_addr;
         end
         // latch the operand so memory need not hold it into phase 3
         if (phase_q == RSF_Q2) begin
            opnd_q <= i_mem_rdata;
         end
         res_q <= res_d;
         if (phase_q == RSF_Q3) begin
            zero_q <= (res_d == RSF_ZERO_BYTE);
         end
      end
   end

   wire op_rot = op_q == RSF_OP_ROT;
   wire op_set = op_q == RSF_OP_SET;
   wire in_q4 = phase_q == RSF_Q4;

   assign o_cyc_start = phase_q == RSF_Q1;
   assign o_mem_addr = addr_q;
   assign o_mem_rd = (phase_q == RSF_Q2) && op_rot;
   assign o_mem_wr = in_q4 && (op_set || (op_rot && dest_f));
   assign o_mem_wdata = res_q;
   assign o_wreg_we = in_q4 && op_rot && !dest_f;
   assign o_wreg_data = res_q;
   // set never touches flags, so only rotate raises the flag strobe
   assign o_flag_we = in_q4 && op_rot;
   assign o_neg_flag = res_q[RSF_SIGN_BIT];
   assign o_zero_flag = zero_q;
   assign o_op_hit = op_rot || op_set;

   // assertions
   sequence rot_read_s;
      phase_q == RSF_Q2 && op_rot;
   endsequence

   sequence rot_write_s;
      in_q4 && (o_mem_wr || o_wreg_we) && o_flag_we;
   endsequence

   // a refused word must not reach memory, working_reg or the flags
   sequence quiet_s;
      !o_op_hit && !o_mem_rd && !o_mem_wr && !o_wreg_we && !o_flag_we;
   endsequence

   rot_result_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      rot_read_s |=> ##1 (res_q == {$past(i_mem_rdata[0], 2),
         $past(i_mem_rdata[7:1], 2)}))
      else $error("rotate result wrong");
   rot_flags_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      o_flag_we |->
         (o_zero_flag == ($past(i_mem_rdata, 2) == RSF_ZERO_BYTE)) &&
         (o_neg_flag == $past(i_mem_rdata[0], 2)))
      else $error("rotate flags wrong");
   rot_dest_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      o_flag_we |-> (o_mem_wr == $past(i_instr[RSF_DEST_BIT], 3)) &&
         (o_wreg_we == !$past(i_instr[RSF_DEST_BIT], 3)))
      else $error("rotate destination wrong");
   bank_select_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && i_instr_vld && i_instr[8] && (is_rot || is_set))
      |=> o_mem_addr[BANK_W+7:8] == $past(i_bank_sel))
      else $error("bank select not used");
   index_mode_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && !i_instr[8] && i_ext_set_en && i_instr[7:0] <= 8'h5F)
      |=> o_mem_addr ==
         $past(i_idx_base) + {{BANK_W{1'b0}}, $past(i_instr[7:0])})
      else $error("indexed address wrong");
   set_write_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && i_instr_vld && is_set) |-> ##3
         (o_mem_wr && o_mem_wdata == 8'hFF && !o_flag_we && !o_wreg_we))
      else $error("set write wrong");
   set_access_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && i_instr_vld && is_set && !i_instr[8] && !i_ext_set_en)
      |=> o_mem_addr[BANK_W+7:8] ==
         ($past(i_instr[7:0]) < 8'h60 ? {BANK_W{1'b0}} : {BANK_W{1'b1}}))
      else $error("set access bank wrong");
   decode_rot_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && i_instr_vld && i_instr[15:10] == 6'b01_0000)
      |-> ##1 o_mem_rd ##2 rot_write_s)
      else $error("rotate not decoded");
   refuse_quiet_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && !(i_instr_vld && (is_rot || is_set)))
      |=> quiet_s [*3])
      else $error("refused word had an effect");
   set_timing_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      (o_cyc_start && i_instr_vld && is_set) |=> !o_mem_rd ##1 !o_mem_wr)
      else $error("set strobes out of phase");
   one_cycle_a: assert property (
      @(posedge i_clk_sys) disable iff (!rst_n)
      o_cyc_start |=> !o_cyc_start [*3] ##1 o_cyc_start)
      else $error("cycle not four phases");
endmodule : rsf_exec
`default_nettype wire

// [pkg/rsf_pkg.sv]
// rsf_pkg: constants and types shared by the rotate/set file-op unit.
// assumes a 16-bit instruction word and a banked byte-wide data memory.
package rsf_pkg;
   // opcode patterns, compared against the upper instruction bits
   localparam logic [5:0] RSF_ROT_OPC = 6'b01_0000;
   localparam logic [6:0] RSF_SET_OPC = 7'b011_0100;
   localparam int RSF_ROT_OPC_MSB = 15;
   localparam int RSF_ROT_OPC_LSB = 10;
   localparam int RSF_SET_OPC_LSB = 9;
   localparam int RSF_DEST_BIT = 9;
   localparam int RSF_ACC_BIT = 8;
   // file addresses at or below this use indexed literal offset mode
   localparam logic [7:0] RSF_IDX_MAX = 8'h5F;
   // access bank: low part maps to bank 0, high part to the top bank
   localparam logic [7:0] RSF_ACC_SPLIT = 8'h60;
   localparam logic [7:0] RSF_ALL_ONES = 8'hFF;
   localparam logic [7:0] RSF_ZERO_BYTE = 8'h00;
   localparam logic [15:0] RSF_INSTR_RST = 16'h0000;
   localparam int RSF_SIGN_BIT = 7;

   typedef enum logic [1:0] {RSF_OP_NONE, RSF_OP_ROT, RSF_OP_SET} rsf_op_t;
   typedef enum logic [1:0] {RSF_Q1, RSF_Q2, RSF_Q3, RSF_Q4} rsf_phase_t;
endpackage : rsf_pkg

// [verif/test_rotate_and_set_file_ops.sv]
// test_rotate_and_set_file_ops: self-checking bench for rsf_exec.
// assumes rsf_pkg is compiled first; inputs move 1 ns after each edge.
`timescale 1ns/1ps
`default_nettype none
module test_rotate_and_set_file_ops;
   import rsf_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic vld = 1'b0;
   logic ext = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bsel = 4'h0;
   logic [11:0] base = 12'h000;
   logic [7:0] rdata = 8'h00;
   logic cyc, rd, wr, wwe, fwe, neg, zero, hit;
   logic [11:0] addr;
   logic [7:0] wdata, wrdata;
   int errors = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   rsf_exec i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_instr(instr),
      .i_instr_vld(vld), .i_ext_set_en(ext), .i_bank_sel(bsel),
      .i_idx_base(base), .i_mem_rdata(rdata), .o_cyc_start(cyc),
      .o_mem_addr(addr), .o_mem_rd(rd), .o_mem_wr(wr),
      .o_mem_wdata(wdata), .o_wreg_we(wwe), .o_wreg_data(wrdata),
      .o_flag_we(fwe), .o_neg_flag(neg), .o_zero_flag(zero),
      .o_op_hit(hit));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // a phase 1 that never comes means the phase counter is stuck
   task automatic wait_p1;
      int n;
      n = 0;
      while (cyc !== 1'b1 && n < 8) begin
         step(1);
         n++;
      end
      if (n == 8) begin
         errors++;
         end_sim();
      end
   endtask : wait_p1
   // one word at phase 1; read data is held until the answer is judged
   task automatic exec(input logic [15:0] ins, input logic [7:0] rdv,
         input logic [11:0] ea, input logic [7:0] res, input logic rot,
         input logic to_w);
      wait_p1();
      instr = ins;
      vld = 1'b1;
      rdata = rdv;
      step(1);
      vld = 1'b0;
      check(addr, ea);
      check(rd, rot);
      check(hit, 1'b1);
      step(1);
      check(rd, 1'b0);
      check(wr, 1'b0);
      check(fwe, 1'b0);
      step(1);
      check(wr, !(rot && to_w));
      check(wwe, rot && to_w);
      check(fwe, rot);
      check(to_w ? wrdata : wdata, res);
      if (rot) begin
         check(neg, res[7]);
         check(zero, res == 8'h00);
      end
   endtask : exec
   task automatic t_rot_file;
      bsel = 4'h5;
      exec(16'h4334, 8'hD7, 12'h534, 8'hEB, 1'b1, 1'b0);
   endtask : t_rot_file
   task automatic t_rot_wreg;
      exec(16'h4080, 8'h00, 12'hF80, 8'h00, 1'b1, 1'b1);
      exec(16'h4010, 8'h01, 12'h010, 8'h80, 1'b1, 1'b1);
   endtask : t_rot_wreg
   task automatic t_set;
      exec(16'h685F, 8'h33, 12'h05F, RSF_ALL_ONES, 1'b0, 1'b0);
      exec(16'h6912, 8'h00, 12'h512, RSF_ALL_ONES, 1'b0, 1'b0);
   endtask : t_set
   // 5Fh is the last indexed address, 60h the first access-bank one
   task automatic t_indexed;
      ext = 1'b1;
      base = 12'h100;
      exec(16'h425F, 8'h80, 12'h15F, 8'h40, 1'b1, 1'b0);
      exec(16'h4260, 8'h02, 12'hF60, 8'h01, 1'b1, 1'b0);
      exec(16'h6800, 8'h00, 12'h100, RSF_ALL_ONES, 1'b0, 1'b0);
      exec(16'h4360, 8'h03, 12'h560, 8'h81, 1'b1, 1'b0);
      ext = 1'b0;
   endtask : t_indexed
   task automatic t_refuse;
      wait_p1();
      instr = 16'h4800;
      vld = 1'b1;
      step(1);
      check(rd, 1'b0);
      check(hit, 1'b0);
      step(2);
      check(wr, 1'b0);
      step(1);
      instr = 16'h6834;
      vld = 1'b0;
      step(3);
      check(wr, 1'b0);
      check(fwe, 1'b0);
   endtask : t_refuse
   // reset dropped mid-instruction: the op must vanish with no strobe
   task automatic t_reset;
      wait_p1();
      instr = 16'h4334;
      vld = 1'b1;
      rdata = 8'hD7;
      step(1);
      rst_b = 1'b0;
      vld = 1'b0;
      #1;
      check(cyc, 1'b1);
      check(rd, 1'b0);
      check(hit, 1'b0);
      step(2);
      check(wr, 1'b0);
      check(fwe, 1'b0);
      rst_b = 1'b1;
      step(2);
      exec(16'h4334, 8'hD7, 12'h534, 8'hEB, 1'b1, 1'b0);
   endtask : t_reset
   initial begin
      step(6);
      rst_b = 1'b1;
      step(3);
      t_rot_file();
      t_rot_wreg();
      t_set();
      t_indexed();
      t_refuse();
      t_reset();
      end_sim();
   end
endmodule : test_rotate_and_set_file_ops
`default_nettype wire
